// File: smci_pkg.sv
package smci_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int BCNT_W = 14;
  localparam int LISTEN_MS = 100;
  localparam int LISTEN_CYC = CLK_HZ / 1000 * LISTEN_MS;
  localparam int LOG_MS = 8;
  localparam int LOG_CYC = CLK_HZ / 1000 * LOG_MS;
  localparam int LOG_STR_MS = 200;
  localparam int LOG_LEN = LOG_STR_MS / LOG_MS;
  localparam int WDOG_MS = 1000;
  localparam int WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
  localparam int CR_ENTRY = 10;
  localparam int DATA_W = 7;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_BANG = 7'h21;
  localparam logic [6:0] CH_QM = 7'h3f;
  localparam logic [6:0] CH_PLUS = 7'h2b;
  localparam logic [6:0] CH_MINUS = 7'h2d;
  localparam logic [6:0] CH_W = 7'h57;
  localparam logic [6:0] CH_Z = 7'h5a;
  localparam logic [6:0] CH_O = 7'h4f;
  localparam logic [6:0] CH_K = 7'h4b;
  localparam logic [6:0] CH_LC_BIT = 7'h20;
  localparam logic [6:0] CH_A = 7'h41;
  localparam logic [6:0] CH_B = 7'h42;
  localparam logic [6:0] CH_C = 7'h43;
  localparam logic [6:0] MOTOR_RST = 7'h00;
  localparam logic ACC_RST = 1'b0;
  // revision, date and hardware code: arbitrary values
  localparam int BANNER_LEN = 16;
  localparam logic [127:0] BANNER = "v0.0 00/00/00\rH\r";
  typedef enum logic [2:0] {
    Q_AMPS, Q_POWER, Q_ANA12, Q_ANA34, Q_HEAT, Q_VOLT, Q_DIGIN, Q_ENC
  } smci_query_type;
  typedef struct packed {
    logic err;
    logic [6:0] data;
  } smci_rx_type;
  typedef struct packed {
    logic rev;
    logic [6:0] value;
  } smci_motor_type;
endpackage

// File: smci_uart.sv
`timescale 1ns/1ps
module smci_uart import smci_pkg::*; #(
  parameter int BIT_CYC_P = BIT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_pin,
  output logic rx_valid,
  output smci_rx_type rx_word,
  input wire logic tx_go,
  input wire logic [DATA_W-1:0] tx_ch,
  output logic tx_busy,
  output logic tx_pin
);
  localparam logic [BCNT_W-1:0] BITM1 = BCNT_W'(BIT_CYC_P - 1);
  localparam logic [BCNT_W-1:0] HALF = BCNT_W'(BIT_CYC_P / 2);
  typedef enum logic {RX_IDLE, RX_BUSY} smci_rxst_type;
  smci_rxst_type rx_st_q, rx_st_d;
  logic rx_s1_q, rx_s2_q;
  logic [BCNT_W-1:0] rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic [3:0] rbit_q, rbit_d, tbit_q, tbit_d;
  logic [7:0] rsh_q, rsh_d;
  logic [9:0] tsh_q, tsh_d;
  logic rx_valid_d, busy_d;
  smci_rx_type rx_word_d;

  // 7 data bits lsb first, even parity, sampled mid-bit
  always_comb begin
    rx_st_d = rx_st_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rx_valid_d = 1'b0;
    rx_word_d = rx_word;
    case (rx_st_q)
      RX_IDLE: if (!rx_s2_q) begin
        rx_st_d = RX_BUSY;
        rcnt_d = HALF;
        rbit_d = 4'h0;
      end
      RX_BUSY: if (rcnt_q != '0) begin
        rcnt_d = rcnt_q - BCNT_W'(1);
      end else begin
        rcnt_d = BITM1;
        rbit_d = rbit_q + 4'h1;
        if (rbit_q == 4'h0) begin
          // glitch, not a start bit
          if (rx_s2_q) rx_st_d = RX_IDLE;
        end else if (rbit_q <= 4'h8) begin
          rsh_d = {rx_s2_q, rsh_q[7:1]};
        end else begin
          rx_st_d = RX_IDLE;
          rx_valid_d = 1'b1;
          rx_word_d.data = rsh_q[6:0];
          rx_word_d.err = !rx_s2_q || (^rsh_q);
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  always_comb begin
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    busy_d = tx_busy;
    if (!tx_busy) begin
      if (tx_go) begin
        busy_d = 1'b1;
        tsh_d = {1'b1, ^tx_ch, tx_ch, 1'b0};
        tcnt_d = BITM1;
        tbit_d = 4'h0;
      end
    end else if (tcnt_q != '0) begin
      tcnt_d = tcnt_q - BCNT_W'(1);
    end else begin
      tcnt_d = BITM1;
      tsh_d = {1'b1, tsh_q[9:1]};
      tbit_d = tbit_q + 4'h1;
      if (tbit_q == 4'h9) busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_st_q <= RX_IDLE;
      rcnt_q <= '0;
      rbit_q <= 4'h0;
      rsh_q <= 8'h00;
      rx_valid <= 1'b0;
      rx_word <= '0;
      tsh_q <= 10'h3ff;
      tcnt_q <= '0;
      tbit_q <= 4'h0;
      tx_busy <= 1'b0;
      tx_pin <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_st_q <= rx_st_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      rx_valid <= rx_valid_d;
      rx_word <= rx_word_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      tx_busy <= busy_d;
      tx_pin <= tsh_d[0];
    end
  end
endmodule

// File: smci_top.sv
`timescale 1ns/1ps
module smci_top import smci_pkg::*; #(
  parameter int BIT_CYC_P = BIT_CYC,
  parameter int LISTEN_CYC_P = LISTEN_CYC,
  parameter int LOG_CYC_P = LOG_CYC,
  parameter int WDOG_CYC_P = WDOG_CYC
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic RXD,
  output logic TXD,
  input wire logic CFG_SERIAL_MODE,
  input wire logic CFG_WDOG_EN,
  output smci_motor_type MOTOR1,
  output smci_motor_type MOTOR2,
  output logic MOTOR_STOP,
  output logic ACC_OUT,
  output logic SERIAL_MODE,
  output logic FW_LOAD_MODE,
  output logic QUERY_STB,
  output smci_query_type QUERY_CODE,
  input wire logic REPLY_VALID,
  input wire logic [DATA_W-1:0] REPLY_CHAR,
  output logic REPLY_READY,
  output logic [4:0] LOG_INDEX,
  input wire logic [DATA_W-1:0] LOG_CHAR
);
  function automatic logic [4:0] hex_nib(input logic [6:0] c);
    if (c >= 7'h30 && c <= 7'h39) hex_nib = {1'b1, c[3:0]};
    else if ((c >= 7'h41 && c <= 7'h46) || (c >= 7'h61 && c <= 7'h66))
      hex_nib = {1'b1, c[3:0] + 4'h9};
    else hex_nib = 5'h00;
  endfunction

  logic rx_valid, tx_busy, rx_ok, cr_eval, lst_on, wd_en;
  smci_rx_type rx_word;
  logic start_q, start_d, serial_q, serial_d, force_q, force_d;
  logic fw_q, fw_d, timeout_q, timeout_d, acc_d, qstb_d;
  logic bn_done_q, bn_done_d, echo_q, echo_d, ack_q, ack_d;
  logic w_q, w_d, ok_q, ok_d, ok_idx_q, ok_idx_d, log_q, log_d;
  logic tx_go_q, tx_go_d, reply_rdy, slot;
  logic cmd_ok, cmd_bad, q_hit;
  logic [3:0] bn_idx_q, bn_idx_d, cr_cnt_q, cr_cnt_d;
  logic [2:0] cnt_q, cnt_d;
  logic [3:0][6:0] buf_q, buf_d;
  logic [6:0] echo_ch_q, echo_ch_d, ack_ch_q, ack_ch_d, tx_ch_q, tx_ch_d;
  logic [6:0] lc;
  logic [4:0] h1, h2, log_idx_d;
  smci_motor_type m1_d, m2_d;
  smci_query_type qcode_d, q_sel;
  logic [26:0] wd_cnt_q, wd_cnt_d;
  logic [19:0] log_cnt_q, log_cnt_d;
  logic [23:0] lst_cnt_q, lst_cnt_d;
  logic lst_over_q, lst_over_d, wd_tick, log_tick;

  smci_uart #(.BIT_CYC_P(BIT_CYC_P)) u_uart (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .rx_pin(RXD),
    .rx_valid(rx_valid),
    .rx_word(rx_word),
    .tx_go(tx_go_q),
    .tx_ch(tx_ch_q),
    .tx_busy(tx_busy),
    .tx_pin(TXD)
  );

  assign rx_ok = rx_valid && !rx_word.err;
  assign lst_on = bn_done_q && !lst_over_q;
  assign cr_eval = rx_ok && serial_q && !fw_q && !(lst_on &&
    rx_word.data == CH_Z) && rx_word.data == CH_CR;
  assign wd_en = serial_q && (force_q || CFG_WDOG_EN);
  assign REPLY_READY = reply_rdy;

  // timers: watchdog, log pacing, firmware-load listen window
  always_comb begin
    wd_tick = 1'b0;
    log_tick = 1'b0;
    lst_cnt_d = lst_cnt_q;
    lst_over_d = lst_over_q;
    if (!wd_en || rx_ok) begin
      wd_cnt_d = '0;
    end else if (wd_cnt_q == 27'(WDOG_CYC_P - 1)) begin
      wd_cnt_d = '0;
      wd_tick = 1'b1;
    end else begin
      wd_cnt_d = wd_cnt_q + 27'h1;
    end
    // one log char per 8 ms
    if (serial_q || !bn_done_q || fw_q) begin
      log_cnt_d = '0;
    end else if (log_cnt_q == 20'(LOG_CYC_P - 1)) begin
      log_cnt_d = '0;
      log_tick = 1'b1;
    end else begin
      log_cnt_d = log_cnt_q + 20'h1;
    end
    if (lst_on) begin
      lst_cnt_d = lst_cnt_q + 24'h1;
      if (lst_cnt_q == 24'(LISTEN_CYC_P - 1)) lst_over_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wd_cnt_q <= '0;
      log_cnt_q <= '0;
      lst_cnt_q <= '0;
      lst_over_q <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_d;
      log_cnt_q <= log_cnt_d;
      lst_cnt_q <= lst_cnt_d;
      lst_over_q <= lst_over_d;
    end
  end

  always_comb begin
    h1 = hex_nib(buf_q[2]);
    h2 = hex_nib(buf_q[3]);
    lc = buf_q[1] | CH_LC_BIT;
    q_hit = 1'b1;
    case (lc)
      7'h61: q_sel = Q_AMPS;
      7'h76: q_sel = Q_POWER;
      7'h70: q_sel = Q_ANA12;
      7'h72: q_sel = Q_ANA34;
      7'h6d: q_sel = Q_HEAT;
      7'h65: q_sel = Q_VOLT;
      7'h69: q_sel = Q_DIGIN;
      7'h6b: q_sel = Q_ENC;
      default: begin
        q_sel = Q_AMPS;
        q_hit = 1'b0;
      end
    endcase
    q_hit = q_hit && cnt_q == 3'h2 && buf_q[0] == CH_QM;
    cmd_ok = buf_q[0] == CH_BANG && ((cnt_q == 3'h2 &&
      (buf_q[1] | CH_LC_BIT) == (CH_C | CH_LC_BIT)) || (cnt_q == 3'h4 &&
      ((lc == (CH_A | CH_LC_BIT)) || (lc == (CH_B | CH_LC_BIT))) &&
      h1[4] && h2[4] && h1[3:0] <= 4'h7));
    cmd_bad = cnt_q != 3'h0 && !cmd_ok && !q_hit;
  end

  // mode, parser and transmit arbitration
  always_comb begin
    start_d = 1'b1;
    serial_d = serial_q;
    force_d = force_q;
    fw_d = fw_q;
    timeout_d = timeout_q;
    acc_d = ACC_OUT;
    m1_d = MOTOR1;
    m2_d = MOTOR2;
    qstb_d = 1'b0;
    qcode_d = QUERY_CODE;
    bn_done_d = bn_done_q;
    bn_idx_d = bn_idx_q;
    echo_d = echo_q;
    echo_ch_d = echo_ch_q;
    ack_d = ack_q;
    ack_ch_d = ack_ch_q;
    w_d = w_q;
    ok_d = ok_q;
    ok_idx_d = ok_idx_q;
    log_d = log_q || log_tick;
    log_idx_d = LOG_INDEX;
    cr_cnt_d = cr_cnt_q;
    cnt_d = cnt_q;
    buf_d = buf_q;
    tx_go_d = 1'b0;
    tx_ch_d = tx_ch_q;
    reply_rdy = 1'b0;
    // mode taken from the stored setting after each reset
    if (!start_q) begin
      serial_d = CFG_SERIAL_MODE;
      ok_d = CFG_SERIAL_MODE;
    end
    if (wd_tick) begin
      timeout_d = 1'b1;
      w_d = 1'b1;
    end
    if (rx_ok) timeout_d = 1'b0;
    slot = start_q && !tx_busy && !tx_go_q;
    if (slot) begin
      tx_go_d = 1'b1;
      if (!bn_done_q) begin
        tx_ch_d = BANNER[8 * (BANNER_LEN - 1 - int'(bn_idx_q)) +: 7];
        bn_idx_d = bn_idx_q + 4'h1;
        if (bn_idx_q == 4'(BANNER_LEN - 1)) bn_done_d = 1'b1;
      end else if (echo_q) begin
        tx_ch_d = echo_ch_q;
        echo_d = 1'b0;
      end else if (ack_q) begin
        tx_ch_d = ack_ch_q;
        ack_d = 1'b0;
      end else if (w_q) begin
        tx_ch_d = CH_W;
        w_d = 1'b0;
      end else begin
        // query replies come from outside as plain chars
        reply_rdy = 1'b1;
        if (REPLY_VALID) begin
          tx_ch_d = REPLY_CHAR;
        end else if (ok_q) begin
          tx_ch_d = ok_idx_q ? CH_K : CH_O;
          ok_idx_d = !ok_idx_q;
          ok_d = !ok_idx_q ? 1'b1 : 1'b0;
        end else if (log_q && !serial_q) begin
          // index wraps so one string spans 200 ms
          tx_ch_d = LOG_CHAR;
          log_d = log_tick;
          log_idx_d = (LOG_INDEX == 5'(LOG_LEN - 1)) ? 5'h00 :
            LOG_INDEX + 5'h01;
        end else begin
          tx_go_d = 1'b0;
        end
      end
    end
    if (serial_q) log_d = 1'b0;
    if (rx_ok && !fw_q) begin
      if (lst_on && rx_word.data == CH_Z) begin
        fw_d = 1'b1;
      end else if (!serial_q) begin
        if (rx_word.data != CH_CR) begin
          cr_cnt_d = 4'h0;
        end else if (cr_cnt_q == 4'(CR_ENTRY - 1)) begin
          cr_cnt_d = 4'h0;
          serial_d = 1'b1;
          force_d = 1'b1;
          ok_d = 1'b1;
          ok_idx_d = 1'b0;
        end else begin
          cr_cnt_d = cr_cnt_q + 4'h1;
        end
      end else begin
        // echo set wins over the send above
        echo_d = 1'b1;
        echo_ch_d = rx_word.data;
        if (rx_word.data != CH_CR) begin
          // store only; overlength saturates and fails at CR
          if (cnt_q < 3'h4) buf_d[cnt_q[1:0]] = rx_word.data;
          if (cnt_q != 3'h5) cnt_d = cnt_q + 3'h1;
        end else begin
          cnt_d = 3'h0;
          if (q_hit) begin
            qstb_d = 1'b1;
            qcode_d = q_sel;
          end else if (cmd_ok) begin
            ack_d = 1'b1;
            ack_ch_d = CH_PLUS;
            if (cnt_q == 3'h2) begin
              acc_d = buf_q[1] == CH_C;
            end else if (lc == (CH_A | CH_LC_BIT)) begin
              m1_d = {buf_q[1][5], h1[2:0], h2[3:0]};
            end else begin
              m2_d = {buf_q[1][5], h1[2:0], h2[3:0]};
            end
          end else if (cmd_bad) begin
            ack_d = 1'b1;
            ack_ch_d = CH_MINUS;
          end
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      start_q <= 1'b0;
      serial_q <= 1'b0;
      force_q <= 1'b0;
      fw_q <= 1'b0;
      timeout_q <= 1'b0;
      ACC_OUT <= ACC_RST;
      MOTOR1 <= {1'b0, MOTOR_RST};
      MOTOR2 <= {1'b0, MOTOR_RST};
      QUERY_STB <= 1'b0;
      QUERY_CODE <= Q_AMPS;
      bn_done_q <= 1'b0;
      bn_idx_q <= 4'h0;
      echo_q <= 1'b0;
      echo_ch_q <= 7'h00;
      ack_q <= 1'b0;
      ack_ch_q <= 7'h00;
      w_q <= 1'b0;
      ok_q <= 1'b0;
      ok_idx_q <= 1'b0;
      log_q <= 1'b0;
      LOG_INDEX <= 5'h00;
      cr_cnt_q <= 4'h0;
      cnt_q <= 3'h0;
      buf_q <= '0;
      tx_go_q <= 1'b0;
      tx_ch_q <= 7'h00;
    end else begin
      start_q <= start_d;
      serial_q <= serial_d;
      force_q <= force_d;
      fw_q <= fw_d;
      timeout_q <= timeout_d;
      ACC_OUT <= acc_d;
      MOTOR1 <= m1_d;
      MOTOR2 <= m2_d;
      QUERY_STB <= qstb_d;
      QUERY_CODE <= qcode_d;
      bn_done_q <= bn_done_d;
      bn_idx_q <= bn_idx_d;
      echo_q <= echo_d;
      echo_ch_q <= echo_ch_d;
      ack_q <= ack_d;
      ack_ch_q <= ack_ch_d;
      w_q <= w_d;
      ok_q <= ok_d;
      ok_idx_q <= ok_idx_d;
      log_q <= log_d;
      LOG_INDEX <= log_idx_d;
      cr_cnt_q <= cr_cnt_d;
      cnt_q <= cnt_d;
      buf_q <= buf_d;
      tx_go_q <= tx_go_d;
      tx_ch_q <= tx_ch_d;
    end
  end

  assign MOTOR_STOP = timeout_q;
  assign SERIAL_MODE = serial_q;
  assign FW_LOAD_MODE = fw_q;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  a_banner_first: assert property ($rose(start_q) |-> ##1 (tx_go_q &&
    tx_ch_q == BANNER[126 -: 7])) else $error("banner not first");
  a_cr_entry_ok: assert property (rx_ok && !serial_q && !fw_q &&
    rx_word.data == CH_CR && cr_cnt_q == 4'h9 && !lst_on |=> serial_q && ok_q)
    else $error("ten CR did not enter serial mode");
  a_entry_forces: assert property (start_q && !serial_q ##1
    serial_q |-> force_q && wd_en) else $error("watchdog not forced");
  a_echo_char: assert property (cr_eval |=> echo_q &&
    echo_ch_q == CH_CR) else $error("char not echoed");
  a_ack_plus: assert property (cr_eval && cmd_ok |=> ack_q &&
    ack_ch_q == CH_PLUS) else $error("missing plus");
  a_nak_minus: assert property (cr_eval && cmd_bad |=> ack_q &&
    ack_ch_q == CH_MINUS && $stable(MOTOR1) && $stable(MOTOR2))
    else $error("bad line not refused");
  a_buf_clear: assert property (cr_eval |=> cnt_q == 3'h0)
    else $error("buffer not cleared");
  a_wdog_stop: assert property (wd_tick && !rx_valid |=>
    MOTOR_STOP && w_q) else $error("timeout not acted on");
  a_query_pulse: assert property (cr_eval && q_hit |=> QUERY_STB
    ##1 !QUERY_STB) else $error("query strobe wrong");
  a_log_tick: assert property (log_tick && !slot |=> log_q)
    else $error("log tick lost");
endmodule

// File: smci_host.sv
`timescale 1ns/1ps
module smci_host import smci_pkg::*; #(
  parameter int BIT_P = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [6:0] rx_q[$];
  logic [9:0] fr;
  int n_bad;

  initial begin
    line_out = 1'b1;
    n_bad = 0;
  end

  task automatic send_char(input logic [6:0] c);
    logic [9:0] f;
    f = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT_P - 1) @(posedge clk);
    end
    @(posedge clk);
  endtask

  // frame check
  // mid-bit sampling, so an edge less than half a bit late or early still reads as a good frame
  always begin
    @(negedge line_in);
    repeat (BIT_P / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = line_in;
      if (i < 9) repeat (BIT_P) @(posedge clk);
    end
    if (fr[0] !== 1'b0 || fr[9] !== 1'b1 || ^fr[8:1] !== 1'b0) n_bad++;
    rx_q.push_back(fr[7:1]);
  end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench import smci_pkg::*;;
  localparam int BITC = 16;
  localparam int LSN = 2000;
  localparam int LOGC = 400;
  localparam int WDC = 3000;
  localparam int CHC = BITC * 10 + 4;
  logic core_clk, arst_n, rxd, txd, cfg_serial, cfg_wdog;
  smci_motor_type motor1, motor2;
  logic motor_stop, acc_out, serial_mode, fw_load, query_stb;
  smci_query_type query_code, last_code;
  logic reply_valid, reply_ready;
  logic [6:0] reply_char, log_char;
  logic [4:0] log_index;
  int n_fail, checks, cyc, n_stb;

  smci_top #(.BIT_CYC_P(BITC), .LISTEN_CYC_P(LSN), .LOG_CYC_P(LOGC),
    .WDOG_CYC_P(WDC)) smci_top_i (.CORE_CLK(core_clk), .ARST_N(arst_n),
    .RXD(rxd), .TXD(txd), .CFG_SERIAL_MODE(cfg_serial),
    .CFG_WDOG_EN(cfg_wdog), .MOTOR1(motor1), .MOTOR2(motor2),
    .MOTOR_STOP(motor_stop), .ACC_OUT(acc_out), .SERIAL_MODE(serial_mode),
    .FW_LOAD_MODE(fw_load), .QUERY_STB(query_stb), .QUERY_CODE(query_code),
    .REPLY_VALID(reply_valid), .REPLY_CHAR(reply_char),
    .REPLY_READY(reply_ready), .LOG_INDEX(log_index), .LOG_CHAR(log_char));
  smci_host #(.BIT_P(BITC)) smci_host_i (.clk(core_clk), .line_in(txd),
    .line_out(rxd));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // log source: each slot carries its own index
  always @(posedge core_clk) log_char <= 7'h60 + {2'b00, log_index};

  always @(posedge core_clk) begin
    if (query_stb === 1'b1) begin
      n_stb <= n_stb + 1;
      last_code <= query_code;
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic get_char(output logic [6:0] c, input int lim);
    int k;
    k = 0;
    while (smci_host_i.rx_q.size() == 0 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (smci_host_i.rx_q.size() == 0) c = 7'bx;
    else c = smci_host_i.rx_q.pop_front();
  endtask

  task automatic expect_str(input string s, input int lim);
    logic [6:0] c;
    for (int i = 0; i < s.len(); i++) begin
      get_char(c, lim);
      check("tx char", c, s[i]);
    end
  endtask

  task automatic send_str(input string s);
    byte b;
    for (int i = 0; i < s.len(); i++) begin
      b = s[i];
      smci_host_i.send_char(b[6:0]);
    end
  endtask

  task automatic line(input string s, ack);
    send_str({s, "\r"});
    expect_str({s, "\r", ack}, 4 * CHC);
  endtask

  task automatic mline(input string s, ack, input logic [15:0] e);
    line(s, ack);
    check("motors", {motor1, motor2}, e);
  endtask

  task automatic do_reset(input logic mode);
    arst_n <= 1'b0;
    cfg_serial <= mode;
    repeat (20) @(posedge core_clk);
    smci_host_i.rx_q.delete();
    arst_n <= 1'b1;
  endtask

  task automatic expect_banner;
    logic [6:0] c;
    for (int i = 0; i < BANNER_LEN; i++) begin
      get_char(c, 2 * CHC);
      check("banner", c, BANNER[126 - 8 * i -: 7]);
    end
  endtask

  task automatic t_serial_start;
    do_reset(1'b1);
    expect_banner();
    expect_str("OK", 2 * CHC);
    check("serial mode", serial_mode, 1'b1);
    repeat (LSN) @(posedge core_clk);
  endtask

  task automatic t_motor;
    mline("!A7F", "+", 16'h7f00);
    mline("!b05", "+", 16'h7f85);
    mline("!a5", "-", 16'h7f85);
    mline("!a05", "+", 16'h8585);
    mline("!A80", "-", 16'h8585);
    mline("!A7F1", "-", 16'h8585);
    mline("!B01", "+", 16'h8501);
    mline("!B3g", "-", 16'h8501);
  endtask

  task automatic t_acc;
    line("!C", "+");
    check("acc on", acc_out, 1'b1);
    line("!c", "+");
    check("acc off", acc_out, 1'b0);
  endtask

  task automatic t_query;
    string q, s;
    byte b;
    int n0, k;
    q = "avprmeik";
    s = "?a";
    for (int i = 0; i < 8; i++) begin
      b = q[i];
      if (i % 2) b = b - 8'h20;
      s.putc(1, b);
      n0 = n_stb;
      line(s, "");
      repeat (CHC) @(posedge core_clk);
      check("query stb", n_stb, n0 + 1);
      check("query code", last_code, i);
    end
    check("no plus", smci_host_i.rx_q.size(), 0);
    reply_char <= 7'h35;
    reply_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (reply_ready !== 1'b1 && k < 4 * CHC);
    @(posedge core_clk);
    reply_valid <= 1'b0;
    expect_str("5", 2 * CHC);
  endtask

  task automatic t_wdog;
    logic [6:0] c;
    int t;
    smci_host_i.rx_q.delete();
    repeat (WDC + 500) @(posedge core_clk);
    check("wdog off", motor_stop, 1'b0);
    check("quiet", smci_host_i.rx_q.size(), 0);
    cfg_wdog <= 1'b1;
    get_char(c, WDC + CHC);
    t = cyc;
    check("wdog char", c, CH_W);
    check("stop", motor_stop, 1'b1);
    get_char(c, WDC + CHC);
    check("repeat char", c, CH_W);
    check("repeat gap", cyc - t, WDC);
    smci_host_i.send_char(7'h01);
    repeat (4) @(posedge core_clk);
    check("restart", motor_stop, 1'b0);
    // let the echo finish so the next reset cannot cut a frame
    get_char(c, 2 * CHC);
    check("ctrl echo", c, 7'h01);
    cfg_wdog <= 1'b0;
  endtask

  task automatic t_rc_mode;
    logic [6:0] c, p;
    int t;
    bit ok;
    do_reset(1'b0);
    expect_banner();
    get_char(c, LOGC + CHC);
    check("log first", c, 7'h60);
    get_char(p, LOGC + CHC);
    t = cyc;
    get_char(c, LOGC + CHC);
    check("log next", c, p + 7'h01);
    check("log gap", cyc - t, LOGC);
    // no terminator, so the carriage-return run below stays unbroken
    send_str("!A10");
    check("rc ignores", motor1, 8'h00);
    send_str("\r\r\r\r\r\r\r\r\r\r");
    ok = 0;
    for (int k = 0; k < 12 && !ok; k++) begin
      p = c;
      get_char(c, 3 * CHC);
      ok = (p == CH_O && c == CH_K);
    end
    check("ok sent", ok, 1'b1);
    check("entered", serial_mode, 1'b1);
    for (int k = 0; k < 4 && c !== CH_W; k++) get_char(c, WDC + CHC);
    check("forced wdog", c, CH_W);
    check("forced stop", motor_stop, 1'b1);
    do_reset(1'b0);
    repeat (4) @(posedge core_clk);
    check("back to rc", serial_mode, 1'b0);
    expect_banner();
  endtask

  task automatic t_fw_load;
    do_reset(1'b1);
    expect_banner();
    smci_host_i.send_char(CH_Z);
    repeat (8) @(posedge core_clk);
    check("fw load", fw_load, 1'b1);
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    cyc = 0;
    n_stb = 0;
    arst_n = 1'b0;
    cfg_serial = 1'b1;
    cfg_wdog = 1'b0;
    reply_valid = 1'b0;
    reply_char = 7'h00;
    log_char = 7'h00;
    t_serial_start();
    t_motor();
    t_acc();
    t_query();
    t_wdog();
    t_rc_mode();
    t_fw_load();
    check("frames", smci_host_i.n_bad, 0);
    tally_and_finish();
  end
endmodule
